/* File: hw/wpw_defs.vh */
// Constants for the windowed program-loop watchdog
`ifndef WPW_DEFS_VH
`define WPW_DEFS_VH

`define WPW_ADDR_W          16
`define WPW_CNT_W           17
`define WPW_REFRESH_ADDR    16'hFF99
`define WPW_OPTION_ADDR     16'h0080
`define WPW_REFRESH_KEY     8'hAC
`define WPW_REFRESH_RST_ON  8'h9A
`define WPW_REFRESH_RST_OFF 8'h1A
`define WPW_EXEMPT_LO       16'hFB00
`define WPW_OPT_LOCK_BIT    0
`define WPW_OPT_OVF_LSB     1
`define WPW_OPT_OVF_MSB     3
`define WPW_OPT_EN_BIT      4
`define WPW_OPT_WIN_LSB     5
`define WPW_OPT_WIN_MSB     6
`define WPW_RSTF_WDT_BIT    4
`define WPW_OSC_STOP_BIT    1
`define WPW_READ_IDLE       8'h00

`endif

/* File: hw/wpw_limits.v */
// Overflow point and closed-window boundary from the option fields
`timescale 1ns/1ps
`include "wpw_defs.vh"

module wpw_limits (
   input  wire [2:0]            overflow_select,
   input  wire [1:0]            window_select,
   output reg  [`WPW_CNT_W-1:0] last_count,
   output reg  [`WPW_CNT_W-1:0] close_end
);

   function [`WPW_CNT_W:0] period_of;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    period_of = 18'h00080;
            3'h1:    period_of = 18'h00100;
            3'h2:    period_of = 18'h00200;
            3'h3:    period_of = 18'h00400;
            3'h4:    period_of = 18'h01000;
            3'h5:    period_of = 18'h04000;
            3'h6:    period_of = 18'h08000;
            default: period_of = 18'h20000;
         endcase
      end
   endfunction

   reg [`WPW_CNT_W:0] period;
   reg [`WPW_CNT_W:0] quarter;
   reg [`WPW_CNT_W:0] closed_span;

   always @* begin
      period      = period_of(overflow_select);
      quarter     = period >> 2;
      // Closed span is the part of the period before the open fraction
      case (window_select)
         2'h0:    closed_span = quarter + (quarter << 1);
         2'h1:    closed_span = quarter << 1;
         2'h2:    closed_span = quarter;
         default: closed_span = 18'h00000;
      endcase
      last_count  = period[`WPW_CNT_W-1:0] - 17'h00001;
      close_end   = closed_span[`WPW_CNT_W-1:0];
   end

endmodule // wpw_limits

/* File: hw/wpw_sync_edge.v */
// Two-stage synchroniser with rising-edge pulse for the low-speed oscillator clock
`timescale 1ns/1ps

module wpw_sync_edge (
   input  wire clk,
   input  wire nrst,
   input  wire async_in,
   output reg  rise_tick
);

   reg stage_a;
   reg stage_b;
   reg stage_c;

   // Only stage_b reads stage_a; the edge detector looks at b and c
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage_a   <= 1'b0;
         stage_b   <= 1'b0;
         stage_c   <= 1'b0;
         rise_tick <= 1'b0;
      end else begin
         stage_a   <= async_in;
         stage_b   <= stage_a;
         stage_c   <= stage_b;
         rise_tick <= stage_b & ~stage_c;
      end
   end

endmodule // wpw_sync_edge

/* File: hw/wpw_watchdog.v */
// Windowed program-loop watchdog top level
`timescale 1ns/1ps
`include "wpw_defs.vh"

module wpw_watchdog (
   input  wire                   clk,
   input  wire                   nrst,
   input  wire                   ls_osc_clk,
   input  wire [7:0]             option_byte,
   input  wire                   wr_en,
   input  wire [`WPW_ADDR_W-1:0] wr_addr,
   input  wire [7:0]             wr_data,
   input  wire                   wr_bit_op,
   input  wire                   rd_en,
   input  wire [`WPW_ADDR_W-1:0] rd_addr,
   input  wire                   fetch_valid,
   input  wire                   fetch_outside,
   input  wire                   acc_valid,
   input  wire [`WPW_ADDR_W-1:0] acc_addr,
   input  wire                   acc_outside,
   input  wire                   halt_mode,
   input  wire                   stop_mode,
   input  wire [7:0]             oscillator_control_register,
   input  wire                   flags_clear,
   output reg  [7:0]             rd_data,
   output reg                    rd_valid,
   output reg                    wdt_reset_req,
   output reg  [7:0]             reset_cause_flags,
   output reg  [`WPW_CNT_W-1:0]  count_value
);

   // Option byte held after reset release
   reg                   cfg_loaded;
   reg  [7:0]            cfg;

   // Counter state
   reg  [`WPW_CNT_W-1:0] count;
   reg                   clr_pend;
   reg                   err_pend;
   reg                   first_done;

   wire                  ls_tick;
   wire [`WPW_CNT_W-1:0] last_count;
   wire [`WPW_CNT_W-1:0] close_end;

   wire                  count_enable_option;
   wire                  oscillator_lock_option;
   wire [2:0]            overflow_select;
   wire [1:0]            window_select;
   wire                  low_speed_osc_stop;
   wire [7:0]            refresh_rst_val;

   reg                   wr_hit;
   reg                   closed_now;
   reg                   bad_write;
   reg                   good_write;
   reg                   illegal_access;
   reg                   osc_running;
   reg                   count_run;
   reg                   overflow_hit;
   reg                   next_req;
   reg  [`WPW_CNT_W-1:0] next_count;
   reg                   next_clr_pend;
   reg                   next_err_pend;
   reg                   next_first_done;

   // The slow clock is sampled, never used as a clock, so no second domain exists
   wpw_sync_edge u_ls_sync (
      .clk       (clk),
      .nrst      (nrst),
      .async_in  (ls_osc_clk),
      .rise_tick (ls_tick)
   );

   wpw_limits u_limits (
      .overflow_select (overflow_select),
      .window_select   (window_select),
      .last_count      (last_count),
      .close_end       (close_end)
   );

   // Option fields; all read as zero until the option byte is caught, except the stop bit from the control register
   assign count_enable_option    = cfg_loaded & cfg[`WPW_OPT_EN_BIT];
   assign oscillator_lock_option = cfg[`WPW_OPT_LOCK_BIT];
   assign overflow_select        = cfg[`WPW_OPT_OVF_MSB:`WPW_OPT_OVF_LSB];
   assign window_select          = cfg[`WPW_OPT_WIN_MSB:`WPW_OPT_WIN_LSB];
   assign low_speed_osc_stop     = oscillator_control_register[`WPW_OSC_STOP_BIT];

   assign refresh_rst_val = count_enable_option ? `WPW_REFRESH_RST_ON : `WPW_REFRESH_RST_OFF;

   // Option byte is a strap: caught by a clock edge after release, not by the reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_loaded <= 1'b0;
         cfg        <= 8'h00;
      end else if (!cfg_loaded) begin
         cfg_loaded <= 1'b1;
         cfg        <= option_byte;
      end
   end

   always @* begin
      wr_hit         = wr_en & (wr_addr == `WPW_REFRESH_ADDR);
      // Boundary test runs against the live count, refreshed every slow tick
      closed_now     = (count < close_end);
      bad_write      = 1'b0;
      good_write     = 1'b0;
      if (count_enable_option & wr_hit) begin
         if (wr_bit_op) begin
            bad_write  = 1'b1;
         end else if (wr_data != `WPW_REFRESH_KEY) begin
            bad_write  = 1'b1;
         end else if (closed_now & first_done) begin
            bad_write  = 1'b1;
         end else begin
            good_write = 1'b1;
         end
      end

      illegal_access = 1'b0;
      if (count_enable_option) begin
         if (fetch_valid & fetch_outside) begin
            illegal_access = 1'b1;
         end
         if (acc_valid & acc_outside & (acc_addr < `WPW_EXEMPT_LO)) begin
            illegal_access = 1'b1;
         end
      end

      // A software-stopped oscillator gives no ticks while the lock bit is clear
      osc_running  = ls_tick & ~(low_speed_osc_stop & ~oscillator_lock_option);
      // Counting goes on in halt_mode and stop_mode; the modes stop it only while the lock bit is clear
      count_run    = osc_running & count_enable_option &
                     ~((halt_mode | stop_mode) & ~oscillator_lock_option);
      overflow_hit = count_run & ~clr_pend & (count == last_count);

      next_req     = illegal_access | (osc_running & err_pend) | overflow_hit;

      next_count      = count;
      next_clr_pend   = clr_pend | good_write;
      next_err_pend   = err_pend | bad_write;
      next_first_done = first_done | (count_enable_option & wr_hit);

      if (count_run) begin
         if (clr_pend) begin
            // Clear waits for a slow edge, which costs up to one slow period
            next_count    = {`WPW_CNT_W{1'b0}};
            next_clr_pend = good_write;
         end else if (!overflow_hit) begin
            next_count    = count + 17'h00001;
         end
      end

      // A watchdog reset restarts the counter state as a fresh release would
      if (next_req) begin
         next_count      = {`WPW_CNT_W{1'b0}};
         next_clr_pend   = 1'b0;
         next_err_pend   = 1'b0;
         next_first_done = 1'b0;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count      <= {`WPW_CNT_W{1'b0}};
         clr_pend   <= 1'b0;
         err_pend   <= 1'b0;
         first_done <= 1'b0;
      end else begin
         count      <= next_count;
         clr_pend   <= next_clr_pend;
         err_pend   <= next_err_pend;
         first_done <= next_first_done;
      end
   end

   // Reset request pulse and sticky cause flag; a new event beats a clear
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wdt_reset_req     <= 1'b0;
         reset_cause_flags <= 8'h00;
         count_value       <= {`WPW_CNT_W{1'b0}};
      end else begin
         wdt_reset_req     <= next_req;
         count_value       <= next_count;
         if (next_req) begin
            reset_cause_flags[`WPW_RSTF_WDT_BIT] <= 1'b1;
         end else if (flags_clear) begin
            reset_cause_flags[`WPW_RSTF_WDT_BIT] <= 1'b0;
         end
      end
   end

   // Read port; the written refresh byte is never stored
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_data  <= `WPW_READ_IDLE;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en && (rd_addr == `WPW_REFRESH_ADDR)) begin
            rd_data <= refresh_rst_val;
         end else if (rd_en && (rd_addr == `WPW_OPTION_ADDR)) begin
            rd_data <= cfg;
         end else begin
            rd_data <= `WPW_READ_IDLE;
         end
      end
   end

endmodule // wpw_watchdog

/* File: testbench/wpw_cpu_model.sv */
// Processor-side model: byte writes and reads at any address the test names
`timescale 1ns/1ps
module wpw_cpu_model (
   input  wire        clk,
   input  wire [7:0]  rd_data,
   output reg         wr_en, wr_bit_op, rd_en,
   output reg  [7:0]  wr_data,
   output reg  [15:0] wr_addr, rd_addr
);
   initial begin
      {wr_en, wr_bit_op, rd_en} = 3'h0;
      {wr_data, wr_addr, rd_addr} = 40'h0;
   end
   // Whole-byte writes; the bit-op flag rises only when a test asks for it
   task wr(input [15:0] a, input [7:0] d, input b);
      @(posedge clk);
      {wr_en, wr_bit_op, wr_addr, wr_data} <= {1'b1, b, a, d};
      @(posedge clk);
      {wr_en, wr_bit_op} <= 2'h0;
      wr_data <= ~d;
   endtask
   task rd(input [15:0] a, output [7:0] d);
      @(posedge clk);
      {rd_en, rd_addr} <= {1'b1, a};
      @(posedge clk);
      {rd_en, rd_addr} <= {1'b0, ~a};
      #1 d = rd_data;
   endtask
endmodule // wpw_cpu_model

/* File: testbench/wpw_watchdog_properties.sv */
// Port-level checks of the watchdog top level
`timescale 1ns/1ps
module wpw_chk (
   input wire        clk, nrst, wr_en, wr_bit_op, rd_en,
   input wire        fetch_valid, fetch_outside, wdt_reset_req, rd_valid,
   input wire [7:0]  option_byte, wr_data, rd_data, oscillator_control_register,
   input wire [7:0]  reset_cause_flags,
   input wire [15:0] wr_addr, rd_addr,
   input wire [16:0] count_value
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   wire        en = option_byte[4];
   // A stopped slow clock defers write errors, so only running-clock writes get a bound
   wire        wr_ref = wr_en && wr_addr == 16'hFF99 && en && !oscillator_control_register[1];
   wire [4:0]  ex = option_byte[3] ? (option_byte[2] ? (option_byte[1] ? 5'h11 : 5'h0F)
                    : (option_byte[1] ? 5'h0E : 5'h0C)) : {3'h0, option_byte[2:1]} + 5'h07;
   wire [16:0] lim = (17'h00001 << ex) - 17'h00001;
   property p_rd;
      rd_en && rd_addr == 16'hFF99 |=> rd_data == (en ? 8'h9A : 8'h1A);
   endproperty
   a_rd: assert property (p_rd) else $error("refresh read value");
   property p_fetch;
      en && fetch_valid && fetch_outside |=> wdt_reset_req;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch reset missing");
   property p_off;
      !en |-> !wdt_reset_req && count_value == 17'h00000;
   endproperty
   a_off: assert property (p_off) else $error("disabled but active");
   property p_flag;
      $rose(wdt_reset_req) |-> reset_cause_flags[4];
   endproperty
   a_flag: assert property (p_flag) else $error("cause flag not set");
   property p_lim;
      count_value <= lim;
   endproperty
   a_lim: assert property (p_lim) else $error("count past overflow");
   property p_clr;
      wr_ref && !wr_bit_op && wr_data == 8'hAC |-> ##[1:30] count_value == 17'h00000;
   endproperty
   a_clr: assert property (p_clr) else $error("refresh did not clear");
   property p_bit;
      wr_ref && wr_bit_op |-> ##[1:30] wdt_reset_req;
   endproperty
   a_bit: assert property (p_bit) else $error("bit op reset missing");
   property p_key;
      wr_ref && !wr_bit_op && wr_data != 8'hAC |-> ##[1:30] wdt_reset_req;
   endproperty
   a_key: assert property (p_key) else $error("bad key reset missing");
   property p_rdv;
      rd_en |=> rd_valid;
   endproperty
   a_rdv: assert property (p_rdv) else $error("read valid missing");
endmodule // wpw_chk
bind wpw_watchdog wpw_chk u_chk (.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_bit_op(wr_bit_op),
   .rd_en(rd_en), .fetch_valid(fetch_valid), .fetch_outside(fetch_outside),
   .wdt_reset_req(wdt_reset_req), .option_byte(option_byte), .wr_data(wr_data),
   .rd_data(rd_data), .oscillator_control_register(oscillator_control_register),
   .reset_cause_flags(reset_cause_flags), .wr_addr(wr_addr), .rd_addr(rd_addr),
   .count_value(count_value), .rd_valid(rd_valid));

/* File: testbench/wpw_watchdog_tb_top.sv */
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module wpw_watchdog_tb_top;
   logic        clk, nrst, ls_osc_clk, fetch_valid, fetch_outside, acc_valid, acc_outside, s;
   logic        halt_mode, stop_mode, flags_clear;
   logic [7:0]  option_byte, oscillator_control_register, d;
   logic [15:0] acc_addr, a;
   logic [16:0] c, mx;
   wire         wr_en, wr_bit_op, rd_en, wdt_reset_req, rd_valid;
   wire  [7:0]  wr_data, rd_data, reset_cause_flags;
   wire  [15:0] wr_addr, rd_addr;
   wire  [16:0] count_value;
   int          err_count = 0, total_checks = 0, seed = 32'h146E9C4B, i;
   wpw_watchdog uut (.clk(clk), .nrst(nrst), .ls_osc_clk(ls_osc_clk), .option_byte(option_byte),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_bit_op(wr_bit_op), .rd_en(rd_en),
      .rd_addr(rd_addr), .fetch_valid(fetch_valid), .fetch_outside(fetch_outside),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_outside(acc_outside),
      .halt_mode(halt_mode), .stop_mode(stop_mode), .flags_clear(flags_clear),
      .oscillator_control_register(oscillator_control_register), .rd_data(rd_data),
      .rd_valid(rd_valid), .wdt_reset_req(wdt_reset_req), .reset_cause_flags(reset_cause_flags),
      .count_value(count_value));
   wpw_cpu_model cpu (.clk(clk), .rd_data(rd_data), .wr_en(wr_en), .wr_bit_op(wr_bit_op),
      .rd_en(rd_en), .wr_data(wr_data), .wr_addr(wr_addr), .rd_addr(rd_addr));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Slow clock, unrelated in phase; it stands still while software holds it off
   initial begin
      ls_osc_clk = 1'b0;
      forever #61 if (!oscillator_control_register[1]) ls_osc_clk = ~ls_osc_clk;
   end
   task chk(input bit ok);
      total_checks++;
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t check failed", $time);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task watch(input int n);
      s = 1'b0;
      repeat (n) begin
         #1;
         if (wdt_reset_req === 1'b1) s = 1'b1;
         if (count_value > mx) mx = count_value;
         @(posedge clk);
      end
   endtask
   task wait_cnt(input [16:0] v);
      repeat (3000) begin
         @(posedge clk);
         #1;
         if (count_value >= v) return;
      end
      chk(1'b0);
      finish_test;
   endtask
   task rst(input [7:0] o);
      nrst <= 1'b0;
      option_byte <= o;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   function automatic [7:0] exp_rd(input [15:0] x);
      if (x == 16'hFF99) return option_byte[4] ? 8'h9A : 8'h1A;
      return x == 16'h0080 ? option_byte : 8'h00;
   endfunction
   initial begin
      {fetch_valid, fetch_outside, acc_valid, acc_outside, halt_mode, stop_mode} = 6'h00;
      {flags_clear, oscillator_control_register, acc_addr} = 25'h0;
      // Shortest overflow with half window keeps runs brief; code 000 never meets window 00
      rst(8'h30);
      for (i = 0; i < 20; i++) begin
         a = 16'($random(seed));
         if (i < 2) a = i ? 16'h0080 : 16'hFF99;
         cpu.rd(a, d);
         chk(d === exp_rd(a) && rd_valid === 1'b1);
         if (a != 16'hFF99) cpu.wr(a, 8'($random(seed)), 1'b0);
      end
      $display("register test done");
      wait_cnt(17'h0000A);
      for (i = 0; i < 3; i++) begin
         if (i == 1) wait_cnt(17'h00046);
         cpu.wr(16'hFF99, 8'hAC, 1'b0);
         watch(30);
         chk(s === (i == 2) && count_value < 17'h00005);
      end
      chk(reset_cause_flags === 8'h10);
      @(posedge clk);
      flags_clear <= 1'b1;
      @(posedge clk);
      flags_clear <= 1'b0;
      #1 chk(reset_cause_flags === 8'h00);
      for (i = 0; i < 2; i++) begin
         cpu.wr(16'hFF99, i ? 8'hAC : 8'h55, i == 1);
         watch(30);
         chk(s === 1'b1);
      end
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         {fetch_valid, fetch_outside, acc_valid, acc_outside} <= {i < 2, i == 0, i > 1, 1'b1};
         acc_addr <= i == 2 ? 16'hFB00 : 16'hFAFF;
         @(posedge clk);
         {fetch_valid, acc_valid} <= 2'h0;
         watch(3);
         chk(s === (i == 0 || i == 3));
      end
      $display("refresh and access tests done");
      for (i = 0; i < 2; i++) begin
         wait_cnt(17'h00014);
         @(posedge clk);
         {halt_mode, stop_mode} <= {i == 0, i == 1};
         repeat (8) @(posedge clk);
         #1 c = count_value;
         repeat (200) @(posedge clk);
         #1 chk(count_value === c);
         @(posedge clk);
         {halt_mode, stop_mode} <= 2'h0;
         repeat (40) @(posedge clk);
         #1 chk(count_value > c && count_value < c + 17'h00005);
      end
      @(posedge clk);
      oscillator_control_register <= 8'h02;
      repeat (8) @(posedge clk);
      #1 c = count_value;
      cpu.wr(16'hFF99, 8'h55, 1'b0);
      watch(60);
      chk(s === 1'b0 && count_value === c);
      oscillator_control_register <= 8'h00;
      watch(30);
      chk(s === 1'b1);
      cpu.wr(16'hFF99, 8'hAC, 1'b0);
      wait_cnt(17'h0007E);
      cpu.wr(16'hFF99, 8'hAC, 1'b0);
      watch(30);
      chk(s === 1'b0);
      mx = 17'h00000;
      watch(2200);
      chk(s === 1'b1 && mx === 17'h0007F);
      $display("low-power and overflow tests done");
      rst(8'h20);
      cpu.rd(16'hFF99, d);
      cpu.wr(16'hFF99, 8'h55, 1'b0);
      watch(40);
      chk(d === exp_rd(16'hFF99) && s === 1'b0 && count_value === 17'h00000);
      $display("disabled test done");
      // Lock bit set, full open window, second overflow code
      rst(8'h73);
      wait_cnt(17'h00003);
      for (i = 0; i < 2; i++) begin
         cpu.wr(16'hFF99, 8'hAC, 1'b0);
         watch(30);
         chk(s === 1'b0 && count_value < 17'h00005);
      end
      @(posedge clk);
      halt_mode <= 1'b1;
      #1 c = count_value;
      repeat (100) @(posedge clk);
      #1 chk(count_value > c);
      @(posedge clk);
      halt_mode <= 1'b0;
      $display("lock and window test done");
      finish_test;
   end
endmodule // wpw_watchdog_tb_top
